// ---- hw/frs_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// [RL1] enter ultra deep sleep on 79h (B9h option)
// [RL2] ABh in ultra sleep: exit, reset, SRAM lost
// [RL3] POR, pattern, pin reset exit ultra sleep
// [RL4] pattern wakes deep sleeps, resets any mode
// [RL5] host holds clock still during pattern
// [RL6] reset on 0101 over four CS rises
// [RL7] SI sampled at chip-select rising edge
// [RL8] host drives SI; device never drives it
// [RL9] fourth matching pulse fires reset, value 5h
// [RL10] any clock edge aborts pattern detection; code sees rising edges only
// [RL11] pattern reset returns single-line SPI mode
// [RL12] 66h then 99h aborts, clears volatile state
// [RL13] other command after 66h disarms reset
// [RL14] host resets first after power-up
// [RL15] host resets then reads ID after wake
// [RL16] host respects minimum sleep dwell time
// [RL17] dwell 550 ms or 750 ms, up to 1500ms
// [RL18] software reset skips configuration reload
// [RL19] mismatch restarts count; low may be first
// [RL20] ultra sleep ignores all but exit command
module frs_ctrl
  import frs_pkg::*;
#(
  parameter bit B9_IS_ULTRA = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic reset_pin_n,
  input wire logic wide_mode_req,
  input wire logic sram_init_done,
  output logic ultra_deep_sleep,
  output logic deep_sleep,
  output logic single_line_mode,
  output logic reset_armed,
  output logic sram_undefined,
  output frs_evt_t evt
);

  // ---------------- link domain (sck) ----------------
  // frame state clears while deselected; sck stops outside frames
  logic link_clr;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [6:0] shift_reg;
  logic [6:0] shift_next;
  logic [7:0] hold_reg;
  logic [7:0] hold_next;
  logic byte_tog_reg;
  logic byte_tog_next;
  logic sck_tog_reg;
  logic sck_tog_next;

  assign link_clr = rst | cs_n;

  // no serial output exists, so the host alone owns si while
  // selected, before and after the first clock edge
  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    shift_next = {shift_reg[5:0], si}; // [RL8]
    hold_next = hold_reg;
    byte_tog_next = byte_tog_reg;
    // every rising clock edge is reported so a pattern in flight dies
    sck_tog_next = ~sck_tog_reg; // [RL10]
    if (bit_cnt_reg != BIT_DONE) begin
      bit_cnt_next = bit_cnt_reg + 4'h1;
    end
    // only the first byte of a frame is an opcode
    if (bit_cnt_reg == BIT_LAST) begin
      hold_next = {shift_reg, si};
      byte_tog_next = ~byte_tog_reg;
    end
  end

  always_ff @(posedge sck or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt_reg <= BIT_CNT_RST;
      shift_reg <= SHIFT_RST;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
    end
  end

  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      hold_reg <= HOLD_RST;
      byte_tog_reg <= TOG_RST;
      sck_tog_reg <= TOG_RST;
    end else begin
      hold_reg <= hold_next;
      byte_tog_reg <= byte_tog_next;
      sck_tog_reg <= sck_tog_next;
    end
  end

  // ---------------- crossings into mclk ----------------
  // hold_reg is stable for at least eight link clocks after its
  // toggle, longer than the two-flop delay at 10 MHz
  logic cs_m1_reg;
  logic cs_m2_reg;
  logic cs_m3_reg;
  logic si_m1_reg;
  logic si_m2_reg;
  logic pin_m1_reg;
  logic pin_m2_reg;
  logic bt_m1_reg;
  logic bt_m2_reg;
  logic bt_m3_reg;
  logic st_m1_reg;
  logic st_m2_reg;
  logic st_m3_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cs_m1_reg <= SYNC_HI_RST;
      cs_m2_reg <= SYNC_HI_RST;
      cs_m3_reg <= SYNC_HI_RST;
      si_m1_reg <= SYNC_RST;
      si_m2_reg <= SYNC_RST;
      pin_m1_reg <= SYNC_HI_RST;
      pin_m2_reg <= SYNC_HI_RST;
      bt_m1_reg <= TOG_RST;
      bt_m2_reg <= TOG_RST;
      bt_m3_reg <= TOG_RST;
      st_m1_reg <= TOG_RST;
      st_m2_reg <= TOG_RST;
      st_m3_reg <= TOG_RST;
    end else begin
      cs_m1_reg <= cs_n;
      cs_m2_reg <= cs_m1_reg;
      cs_m3_reg <= cs_m2_reg;
      si_m1_reg <= si;
      si_m2_reg <= si_m1_reg;
      pin_m1_reg <= reset_pin_n;
      pin_m2_reg <= pin_m1_reg;
      bt_m1_reg <= byte_tog_reg;
      bt_m2_reg <= bt_m1_reg;
      bt_m3_reg <= bt_m2_reg;
      st_m1_reg <= sck_tog_reg;
      st_m2_reg <= st_m1_reg;
      st_m3_reg <= st_m2_reg;
    end
  end

  logic cs_rise;
  logic byte_valid;
  logic sck_seen;
  logic pin_reset;

  // si rides the same two flops as cs_n, so the level seen beside
  // the chip-select rise is the one the host set up for that pulse
  assign cs_rise = cs_m2_reg & ~cs_m3_reg; // [RL7]
  assign byte_valid = bt_m2_reg ^ bt_m3_reg;
  assign sck_seen = st_m2_reg ^ st_m3_reg;
  assign pin_reset = ~pin_m2_reg;

  // ---------------- chip-select reset pattern ----------------
  logic [1:0] pat_step_reg;
  logic [1:0] pat_step_next;
  logic pat_fire;
  logic pat_expect;

  // a frame's closing rise may still count as a step; its clocks
  // already cleared the count, so at most one stray step remains

  always_comb begin
    pat_step_next = pat_step_reg;
    pat_fire = 1'b0;
    pat_expect = PAT_VALUE[2'h3 - pat_step_reg]; // [RL6]
    if (sck_seen) begin
      pat_step_next = PAT_STEP_RST; // [RL10]
    end else if (cs_rise) begin
      if (si_m2_reg == pat_expect) begin
        if (pat_step_reg == PAT_LAST) begin
          pat_fire = 1'b1; // [RL9]
          pat_step_next = PAT_STEP_RST;
        end else begin
          pat_step_next = pat_step_reg + 2'h1; // [RL6]
        end
      end else if (!si_m2_reg) begin
        // a stray low may open a fresh pattern
        pat_step_next = 2'h1; // [RL19]
      end else begin
        pat_step_next = PAT_STEP_RST; // [RL19]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pat_step_reg <= PAT_STEP_RST;
    end else begin
      pat_step_reg <= pat_step_next;
    end
  end

  // ---------------- power state and resets ----------------
  frs_state_t state_reg;
  frs_state_t state_next;
  logic armed_reg;
  logic armed_next;
  logic wide_reg;
  logic wide_next;
  logic sram_undef_reg;
  logic sram_undef_next;
  frs_evt_t evt_reg;
  frs_evt_t evt_next;
  logic hard_reset;
  logic [7:0] cmd;

  // pin and pattern resets share one path and both reload settings
  assign hard_reset = pat_fire | pin_reset;
  assign cmd = hold_reg;

  always_comb begin
    state_next = state_reg;
    armed_next = armed_reg;
    wide_next = wide_reg;
    sram_undef_next = sram_undef_reg;
    evt_next = EVT_NONE;
    if (hard_reset) begin
      // full restart with reload, from any mode
      state_next = FRS_ACTIVE; // [RL3] [RL4]
      armed_next = 1'b0;
      wide_next = 1'b0; // [RL11]
      sram_undef_next = 1'b1; // [RL3]
      evt_next.core_reset = 1'b1;
      evt_next.config_reload = 1'b1;
      evt_next.volatile_clear = 1'b1;
      evt_next.sram_lost = 1'b1;
    end else if (byte_valid) begin
      case (state_reg)
        FRS_ULTRA: begin
          // everything else is ignored while asleep
          if (cmd == OP_WAKE) begin // [RL20]
            state_next = FRS_ACTIVE; // [RL2]
            sram_undef_next = 1'b1;
            evt_next.core_reset = 1'b1;
            evt_next.sram_lost = 1'b1;
          end
        end
        FRS_DEEP: begin
          if (cmd == OP_WAKE) begin
            state_next = FRS_ACTIVE;
          end
        end
        default: begin
          armed_next = 1'b0; // [RL13]
          if (cmd == OP_RST_ENABLE) begin
            armed_next = 1'b1; // [RL13]
          end else if (cmd == OP_RST_EXEC && armed_reg) begin
            // no reload: a corrupted setting survives this one
            wide_next = 1'b0; // [RL12]
            evt_next.core_reset = 1'b1; // [RL12]
            evt_next.volatile_clear = 1'b1; // [RL12] [RL18]
          end else if (cmd == OP_ULTRA_ENTER) begin
            state_next = FRS_ULTRA; // [RL1]
          end else if (cmd == OP_ALT_SLEEP) begin
            // meaning of B9h differs per variant, hence the parameter
            state_next = B9_IS_ULTRA ? FRS_ULTRA : FRS_DEEP; // [RL1]
          end
        end
      endcase
    end else begin
      if (wide_mode_req && state_reg == FRS_ACTIVE) begin
        wide_next = 1'b1;
      end
      // init-done loses against a reset in the same cycle
      if (sram_init_done) begin
        sram_undef_next = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= STATE_RST;
      armed_reg <= ARMED_RST;
      wide_reg <= WIDE_RST;
      sram_undef_reg <= SRAM_UNDEF_RST; // [RL3]
      evt_reg <= EVT_NONE;
    end else begin
      state_reg <= state_next;
      armed_reg <= armed_next;
      wide_reg <= wide_next;
      sram_undef_reg <= sram_undef_next;
      evt_reg <= evt_next;
    end
  end

  assign ultra_deep_sleep = (state_reg == FRS_ULTRA);
  assign deep_sleep = (state_reg == FRS_DEEP);
  assign single_line_mode = ~wide_reg;
  assign reset_armed = armed_reg;
  assign sram_undefined = sram_undef_reg;
  assign evt = evt_reg;

endmodule
`default_nettype wire

// ---- hw/frs_pkg.sv ----
package frs_pkg;

  // opcodes seen as the first byte of a selected frame
  localparam logic [7:0] OP_ULTRA_ENTER = 8'h79;
  localparam logic [7:0] OP_ALT_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE = 8'hAB;
  localparam logic [7:0] OP_RST_ENABLE = 8'h66;
  localparam logic [7:0] OP_RST_EXEC = 8'h99;

  // chip-select pattern: low, high, low, high
  localparam logic [3:0] PAT_VALUE = 4'h5;
  localparam logic [1:0] PAT_LAST = 2'h3;
  localparam logic [1:0] PAT_STEP_RST = 2'h0;

  // link shifter
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_DONE = 4'h8;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [6:0] SHIFT_RST = 7'h00;
  localparam logic [7:0] HOLD_RST = 8'h00;

  typedef enum logic [1:0] {
    FRS_ACTIVE = 2'b00,
    FRS_DEEP = 2'b01,
    FRS_ULTRA = 2'b11
  } frs_state_t;

  typedef struct packed {
    logic core_reset;
    logic config_reload;
    logic volatile_clear;
    logic sram_lost;
  } frs_evt_t;

  localparam frs_evt_t EVT_NONE = '0;
  localparam frs_state_t STATE_RST = FRS_ACTIVE;
  localparam logic ARMED_RST = 1'b0;
  localparam logic WIDE_RST = 1'b0;
  localparam logic SRAM_UNDEF_RST = 1'b1;
  localparam logic TOG_RST = 1'b0;
  localparam logic SYNC_RST = 1'b0;
  localparam logic SYNC_HI_RST = 1'b1;

endpackage

// ---- sim/frs_ctrl_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module frs_ctrl_asserts
  import frs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic reset_pin_n,
  input wire logic ultra_deep_sleep,
  input wire logic deep_sleep,
  input wire logic single_line_mode,
  input wire logic reset_armed,
  input wire logic sram_undefined,
  input wire frs_evt_t evt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_pin_low;
    !reset_pin_n [*5];
  endsequence
  sequence s_ultra_quiet;
    (ultra_deep_sleep && cs_n && reset_pin_n) [*8];
  endsequence
  property p_rst_val;
    $fell(rst) |-> single_line_mode && sram_undefined && !reset_armed && !ultra_deep_sleep;
  endproperty
  property p_one_sleep;
    !(ultra_deep_sleep && deep_sleep);
  endproperty
  property p_hard;
    evt.config_reload |-> single_line_mode && !ultra_deep_sleep && !deep_sleep && !reset_armed;
  endproperty
  property p_sw;
    evt.volatile_clear |-> evt.core_reset;
  endproperty
  property p_lost;
    evt.sram_lost |-> sram_undefined;
  endproperty
  property p_pin;
    s_pin_low |-> evt.core_reset && evt.sram_lost;
  endproperty
  property p_ultra_hold;
    s_ultra_quiet |=> ultra_deep_sleep;
  endproperty
  property p_armed;
    $rose(reset_armed) |-> !ultra_deep_sleep && !deep_sleep;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad state after reset");
  a_one_sleep: assert property (p_one_sleep) else $error("two sleep modes");
  a_hard: assert property (p_hard) else $error("hard reset state wrong");
  a_sw: assert property (p_sw) else $error("clear without reset");
  a_lost: assert property (p_lost) else $error("sram not flagged");
  a_pin: assert property (p_pin) else $error("pin reset missing");
  a_ultra_hold: assert property (p_ultra_hold) else $error("left sleep");
  a_armed: assert property (p_armed) else $error("armed while asleep");
endmodule
bind frs_ctrl frs_ctrl_asserts i_asserts (.mclk, .rst, .cs_n, .reset_pin_n, .ultra_deep_sleep,
  .deep_sleep, .single_line_mode, .reset_armed, .sram_undefined, .evt);
`default_nettype wire

// ---- sim/frs_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module frs_host #(
  parameter int DWELL_NS = 3000
) (
  output logic sck,
  output logic cs_n,
  output logic si
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b1;
  end
  // mode 0, clock only inside frames
  task automatic frame(input logic [7:0] op);
    cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      si = op[i];
      #24 sck = 1'b1;
      #24 sck = 1'b0;
    end
    #24 cs_n = 1'b1;
    #24 si = ~si; // no pull on si, so never leave the last bit
    #600;
  endtask
  task automatic pulse(input logic b, input logic glitch);
    cs_n = 1'b0;
    si = b;
    if (glitch) begin
      #100 sck = 1'b1;
      #100 sck = 1'b0;
    end
    #500 cs_n = 1'b1; // clock still otherwise
    #400 si = ~b;
    #100;
  endtask
  // shortened stand-in for the long discharge wait
  task automatic dwell;
    #DWELL_NS;
  endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
  import frs_pkg::*;
  logic mclk;
  logic rst;
  logic reset_pin_n;
  logic wide_mode_req;
  logic sram_init_done;
  logic ultra;
  logic deep;
  logic single;
  logic armed;
  logic sram_u;
  logic ultra_b;
  logic deep_b;
  logic single_b;
  logic armed_b;
  logic sram_b;
  wire logic sck;
  wire logic cs_n;
  wire logic si;
  frs_evt_t evt;
  frs_evt_t last_evt;
  frs_evt_t exp_q[$];
  int mismatches;
  int total_checks;
  logic [7:0] op;
  frs_host i_host (
    .sck(sck),
    .cs_n(cs_n),
    .si(si)
  );
  frs_ctrl #(
    .B9_IS_ULTRA(1'b0)
  ) i_dut (
    .mclk(mclk),
    .rst(rst),
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .reset_pin_n(reset_pin_n),
    .wide_mode_req(wide_mode_req),
    .sram_init_done(sram_init_done),
    .ultra_deep_sleep(ultra),
    .deep_sleep(deep),
    .single_line_mode(single),
    .reset_armed(armed),
    .sram_undefined(sram_u),
    .evt(evt)
  );
  // second copy in which B9h means ultra deep sleep
  frs_ctrl #(
    .B9_IS_ULTRA(1'b1)
  ) i_dut_b9 (
    .mclk(mclk),
    .rst(rst),
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .reset_pin_n(reset_pin_n),
    .wide_mode_req(wide_mode_req),
    .sram_init_done(sram_init_done),
    .ultra_deep_sleep(ultra_b),
    .deep_sleep(deep_b),
    .single_line_mode(single_b),
    .reset_armed(armed_b),
    .sram_undefined(sram_b),
    .evt()
  );
  task automatic report_and_stop;
    mismatches += exp_q.size();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_evt(input frs_evt_t e);
    total_checks++;
    if (evt !== e) begin
      mismatches++;
      $display("unexpected evt %h at %0t", evt, $time);
    end
  endtask
  task automatic chk_lvl(input logic [4:0] e);
    repeat (4) @(posedge mclk);
    total_checks++;
    if ({ultra, deep, single, armed, sram_u} !== e) begin
      mismatches++;
      $display("unexpected state at %0t", $time);
    end
  endtask
  task automatic chk_alt(input logic [4:0] e);
    total_checks++;
    if ({ultra_b, deep_b, single_b, armed_b, sram_b} !== e) begin
      mismatches++;
      $display("unexpected alt state at %0t", $time);
    end
  endtask
  task automatic strobe(input int w);
    @(posedge mclk);
    if (w) wide_mode_req <= 1'b1;
    else sram_init_done <= 1'b1;
    @(posedge mclk);
    wide_mode_req <= 1'b0;
    sram_init_done <= 1'b0;
  endtask
  task automatic pattern(input int n, input logic [5:0] b, input logic [5:0] g);
    for (int i = n - 1; i >= 0; i--) i_host.pulse(b[i], g[i]);
  endtask
  // only the first cycle of a burst counts; pin reset pulses as a level
  always @(posedge mclk) begin
    if (!rst && evt !== EVT_NONE && last_evt === EVT_NONE)
      chk_evt(exp_q.size() ? exp_q.pop_front() : EVT_NONE);
    last_evt <= evt;
  end
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #200000;
    mismatches++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1;
    reset_pin_n = 1'b1;
    wide_mode_req = 1'b0;
    sram_init_done = 1'b0;
    last_evt = EVT_NONE;
    void'($urandom(32'h97D7));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    chk_lvl(5'h05);
    exp_q.push_back(4'hF);
    pattern(4, 6'h05, 6'h00);
    chk_lvl(5'h05);
    strobe(0);
    i_host.frame(8'h79);
    chk_lvl(5'h14);
    i_host.dwell;
    i_host.frame(8'h66);
    chk_lvl(5'h14);
    exp_q.push_back(4'h9);
    i_host.frame(8'hAB);
    chk_lvl(5'h05);
    exp_q.push_back(4'hF);
    @(posedge mclk) reset_pin_n <= 1'b0;
    repeat (6) @(posedge mclk);
    reset_pin_n <= 1'b1;
    chk_lvl(5'h05);
    strobe(1);
    i_host.frame(8'hB9);
    chk_lvl(5'h09);
    chk_alt(5'h11);
    exp_q.push_back(4'hF);
    pattern(6, 6'h25, 6'h00);
    chk_lvl(5'h05);
    chk_alt(5'h05);
    pattern(4, 6'h05, 6'h02);
    chk_lvl(5'h05);
    strobe(0);
    i_host.frame(8'h66);
    chk_lvl(5'h06);
    do op = 8'($urandom); while (op inside {8'h66, 8'h99, 8'h79, 8'hB9, 8'hAB});
    i_host.frame(op);
    i_host.frame(8'h99);
    chk_lvl(5'h04);
    strobe(1);
    i_host.frame(8'h66);
    exp_q.push_back(4'hA);
    i_host.frame(8'h99);
    chk_lvl(5'h04);
    report_and_stop;
  end
endmodule
`default_nettype wire
